/* rtl/vgc_pkg.sv */
// Package with register map, field positions and codes for the graphics controller
package vgc_pkg;
	// I/O port addresses
	localparam logic [15:0] VGC_ADR_MISC_W  = 16'h03C2;
	localparam logic [15:0] VGC_ADR_INPUT_STATUS_ZERO  = 16'h03C2;
	localparam logic [15:0] VGC_ADR_MISC_R  = 16'h03CC;
	localparam logic [15:0] VGC_ADR_SEQ_X   = 16'h03C4;
	localparam logic [15:0] VGC_ADR_SEQ_D   = 16'h03C5;
	localparam logic [15:0] VGC_ADR_GC_X    = 16'h03CE;
	localparam logic [15:0] VGC_ADR_GC_D    = 16'h03CF;
	localparam logic [15:0] VGC_ADR_STAT_M  = 16'h03BA;
	localparam logic [15:0] VGC_ADR_STAT_C  = 16'h03DA;
	// Graphics controller indices
	localparam logic [3:0] VGC_GI_SETRST = 4'h0;
	localparam logic [3:0] VGC_GI_SRENA  = 4'h1;
	localparam logic [3:0] VGC_GI_CCMP   = 4'h2;
	localparam logic [3:0] VGC_GI_ROT    = 4'h3;
	localparam logic [3:0] VGC_GI_RMAP   = 4'h4;
	localparam logic [3:0] VGC_GI_MODE   = 4'h5;
	localparam logic [3:0] VGC_GI_MISC   = 4'h6;
	localparam logic [3:0] VGC_GI_CARE   = 4'h7;
	localparam logic [3:0] VGC_GI_MASK   = 4'h8;
	// Sequencer indices
	localparam logic [2:0] VGC_SI_RST    = 3'h0;
	localparam logic [2:0] VGC_SI_CLK    = 3'h1;
	localparam logic [2:0] VGC_SI_MMASK  = 3'h2;
	localparam logic [2:0] VGC_SI_CMAP   = 3'h3;
	localparam logic [2:0] VGC_SI_MEM    = 3'h4;
	// Write masks of implemented bits
	localparam logic [7:0] VGC_WM_ROT    = 8'h1F;
	localparam logic [7:0] VGC_WM_RMAP   = 8'h03;
	localparam logic [7:0] VGC_WM_MODE   = 8'h7B;
	localparam logic [7:0] VGC_WM_MISC   = 8'h0F;
	localparam logic [7:0] VGC_WM_NIB    = 8'h0F;
	localparam logic [7:0] VGC_WM_SRST   = 8'h03;
	localparam logic [7:0] VGC_WM_SCLK   = 8'h3D;
	localparam logic [7:0] VGC_WM_SCMAP  = 8'h3F;
	localparam logic [7:0] VGC_WM_SMEM   = 8'h0E;
	localparam logic [7:0] VGC_WM_MISCO  = 8'hEF;
	// Reset values
	localparam logic [7:0] VGC_RST_ZERO  = 8'h00;
	localparam logic [7:0] VGC_RST_MASK  = 8'hFF;
	// Fixed input status 0 bits: switch sense and feature inputs
	localparam logic [7:0] VGC_INPUT_STATUS_ZERO_FIX = 8'h70;
	// Field positions
	localparam int VGC_F_ROT_LO   = 0;
	localparam int VGC_F_FUN_LO   = 3;
	localparam int VGC_F_WRM_LO   = 0;
	localparam int VGC_F_RDMODE   = 3;
	localparam int VGC_F_RODDEV   = 4;
	localparam int VGC_F_INTLV    = 5;
	localparam int VGC_F_WIDE     = 6;
	localparam int VGC_F_GRSEL    = 0;
	localparam int VGC_F_CHODD    = 1;
	localparam int VGC_F_MAP_LO   = 2;
	localparam int VGC_F_IOSEL    = 0;
	localparam int VGC_F_RAMEN    = 1;
	localparam int VGC_F_CLK_LO   = 2;
	localparam int VGC_F_PAGE     = 5;
	localparam int VGC_F_HPOL     = 6;
	localparam int VGC_F_VPOL     = 7;
	localparam int VGC_F_CHAIN_FOUR_BIT   = 3;
	localparam int VGC_F_VINT     = 7;
	localparam int VGC_F_DISP     = 0;
	localparam int VGC_F_VRET     = 3;
	localparam int VGC_F_DIAG_LO  = 4;
	localparam int VGC_HOST_A16   = 16;
	// Write mode codes
	typedef enum logic [1:0] {
		VGC_WM0 = 2'h0,
		VGC_WM1 = 2'h1,
		VGC_WM2 = 2'h2,
		VGC_WM3 = 2'h3
	} vgc_wmode_t;
	// Logic unit function codes
	typedef enum logic [1:0] {
		VGC_FN_PASS = 2'h0,
		VGC_FN_AND  = 2'h1,
		VGC_FN_OR   = 2'h2,
		VGC_FN_XOR  = 2'h3
	} vgc_func_t;
	// Memory window codes and bounds (host address bits 19:12)
	localparam logic [1:0] VGC_MAP_128K = 2'h0;
	localparam logic [1:0] VGC_MAP_A64K = 2'h1;
	localparam logic [1:0] VGC_MAP_B32K = 2'h2;
	localparam logic [7:0] VGC_WIN_A0   = 8'hA0;
	localparam logic [7:0] VGC_WIN_B0   = 8'hB0;
	localparam logic [7:0] VGC_WIN_B8   = 8'hB8;
	localparam logic [7:0] VGC_WIN_END  = 8'hC0;
	// Clock source codes
	localparam logic [1:0] VGC_CLK_25M  = 2'h0;
	localparam logic [1:0] VGC_CLK_28M  = 2'h1;
endpackage

/* rtl/vgc_write_path.sv */
// Write datapath: rotation, set/reset, logic unit and pixel mask
`timescale 1ns/1ps
module vgc_write_path
	import vgc_pkg::*;
(
	// Controls
	input  wire logic [1:0]  wr_mode,
	input  wire logic [2:0]  rot_cnt,
	input  wire logic [1:0]  func_sel,
	input  wire logic [3:0]  set_reset,
	input  wire logic [3:0]  set_reset_en,
	input  wire logic [7:0]  bit_mask,
	// Data
	input  wire logic [7:0]  host_byte,
	input  wire logic [31:0] latch_data,
	output logic      [31:0] plane_out
);
	logic [7:0]  rot_byte;
	logic [7:0]  pix_mask;

	// Right rotate of host byte
	assign rot_byte = 8'((host_byte >> rot_cnt) | (host_byte << (4'd8 - rot_cnt)));

	// Effective pixel mask; mode 3 ANDs rotated data with mask
	assign pix_mask = (wr_mode == VGC_WM3) ? (rot_byte & bit_mask) : bit_mask;

	// Per plane source selection and logic unit
	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_plane
			logic [7:0] src_p;
			logic [7:0] alu_p;
			logic [7:0] out_p;
			always_comb begin
				case (wr_mode)
					VGC_WM0: src_p = set_reset_en[p] ? {8{set_reset[p]}}
						: rot_byte;
					VGC_WM2: src_p = {8{host_byte[p]}};
					VGC_WM3: src_p = {8{set_reset[p]}};
					default: src_p = latch_data[p*8 +: 8];
				endcase
				case (func_sel)
					VGC_FN_AND: alu_p = src_p & latch_data[p*8 +: 8];
					VGC_FN_OR:  alu_p = src_p | latch_data[p*8 +: 8];
					VGC_FN_XOR: alu_p = src_p ^ latch_data[p*8 +: 8];
					default:    alu_p = src_p;
				endcase
				if (wr_mode == VGC_WM1) begin
					out_p = latch_data[p*8 +: 8];
				end else begin
					out_p = (alu_p & pix_mask)
						| (latch_data[p*8 +: 8] & ~pix_mask);
				end
			end
			// One driver per plane slice
			assign plane_out[p*8 +: 8] = out_p;
		end
	endgenerate
endmodule

/* rtl/vgc_read_path.sv */
// Read datapath: plane select and colour compare
`timescale 1ns/1ps
module vgc_read_path
	import vgc_pkg::*;
(
	// Controls
	input  wire logic        rd_mode,
	input  wire logic [1:0]  plane_sel,
	input  wire logic [3:0]  ref_colour,
	input  wire logic [3:0]  care_en,
	// Data
	input  wire logic [31:0] latch_data,
	output logic      [7:0]  read_byte
);
	logic [7:0] cmp;

	// Colour compare per pixel, only cared planes count
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_pix
			assign cmp[b] = ~|(({latch_data[24+b], latch_data[16+b],
				latch_data[8+b], latch_data[b]} ^ ref_colour) & care_en);
		end
	endgenerate

	// Read mode selects compare or plane
	assign read_byte = rd_mode ? cmp : latch_data[plane_sel*8 +: 8];
endmodule

/* rtl/vgc_regs.sv */
// Graphics controller register bank and datapath top
// Functional notes
// - Mode 0 right-rotates host byte
// - Logic unit: pass, AND, OR, XOR
// - Read mode 0 uses read plane field
// - Mode 0 rotates then applies set/reset
// - Mode 1 writes latches directly
// - Mode 2 replicates data bit per plane
// - Mode 3 expands set/reset, rotated data masks
// - Read mode bit picks compare; chain-four overrides read plane
// - Read odd/even puts A0 in plane bit 0
// - Interleave and wide colour load controls
// - Graphics select: alpha or graphics mode
// - Chain odd/even replaces memory A0
// - Map window field sets host window
// - Only cared planes join colour compare
// - Zero mask bit keeps pixel unchanged
// - Status 0 fixed switch and feature bits
// - Status 0 bit 7 shows pending retrace
// - Status 1 display-inactive and retrace bits
// - Diagnostic bits follow colour mux field
// - Address select moves CRTC/status ports
// - Clock select picks source clock
// - Sync polarity bits invert sync pulses
`timescale 1ns/1ps
module vgc_regs
	import vgc_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// Host I/O register port
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	output logic             io_hit,
	// Host frame buffer access
	input  wire logic [19:0] mem_addr,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic             mem_hit,
	// Video memory side
	input  wire logic [31:0] vram_rdata,
	output logic      [31:0] vram_wdata,
	output logic      [15:0] vram_addr,
	output logic      [3:0]  vram_plane_we,
	// Display status inputs
	input  wire logic        vint_pending,
	input  wire logic        disp_inactive,
	input  wire logic        vretrace_act,
	input  wire logic [1:0]  colour_mux_sel,
	input  wire logic [7:0]  attr_colour,
	input  wire logic        hsync_raw,
	input  wire logic        vsync_raw,
	// Controls to display side
	output logic             crtc_cga_map,
	output logic [1:0]       clock_source,
	output logic             ext_pixel_clk,
	output logic             hsync_out,
	output logic             vsync_out,
	output logic             graphics_mode,
	output logic             interleave_en,
	output logic             wide_colour_load_bit,
	output logic [7:0]       seq_clock_mode
);
	logic [1:0]  rst_sync_q;
	logic        rst_n;
	logic [7:0]  misc_q;
	logic [3:0]  gc_idx_q;
	logic [2:0]  seq_idx_q;
	logic [7:0]  setrst_q, srena_q, ccmp_q, rot_q, rmap_q;
	logic [7:0]  mode_q, gmisc_q, care_q, mask_q;
	logic [7:0]  srst_q, sclk_q, mmask_q, cmap_q, smem_q;
	logic [31:0] latch_q;
	logic [7:0]  gc_rd, seq_rd, stat0, stat1;
	logic [1:0]  diag;
	logic [1:0]  rd_plane;
	logic [7:0]  rd_byte;
	logic [31:0] wr_planes;
	logic        in_win;
	logic [7:0]  pg;
	logic        stat_addr;
	logic        chain_four_bit;
	logic [3:0]  we_planes;
	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];
	// Status port follows I/O address select
	assign stat_addr = (io_addr == (misc_q[VGC_F_IOSEL] ? VGC_ADR_STAT_C
		: VGC_ADR_STAT_M));
	// Miscellaneous output register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			misc_q <= VGC_RST_ZERO;
		end else if (io_wr && io_addr == VGC_ADR_MISC_W) begin
			misc_q <= io_wdata & VGC_WM_MISCO;
		end
	end
	// Index registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gc_idx_q  <= 4'h0;
			seq_idx_q <= 3'h0;
		end else if (io_wr) begin
			if (io_addr == VGC_ADR_GC_X) begin
				gc_idx_q <= io_wdata[3:0];
			end else if (io_addr == VGC_ADR_SEQ_X) begin
				seq_idx_q <= io_wdata[2:0];
			end
		end
	end
	// Graphics controller data registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			setrst_q <= VGC_RST_ZERO;
			srena_q  <= VGC_RST_ZERO;
			ccmp_q   <= VGC_RST_ZERO;
			rot_q    <= VGC_RST_ZERO;
			rmap_q   <= VGC_RST_ZERO;
			mode_q   <= VGC_RST_ZERO;
			gmisc_q  <= VGC_RST_ZERO;
			care_q   <= VGC_RST_ZERO;
			mask_q   <= VGC_RST_MASK;
		end else if (io_wr && io_addr == VGC_ADR_GC_D) begin
			if (gc_idx_q == VGC_GI_SETRST) begin
				setrst_q <= io_wdata & VGC_WM_NIB;
			end else if (gc_idx_q == VGC_GI_SRENA) begin
				srena_q <= io_wdata & VGC_WM_NIB;
			end else if (gc_idx_q == VGC_GI_CCMP) begin
				ccmp_q <= io_wdata & VGC_WM_NIB;
			end else if (gc_idx_q == VGC_GI_ROT) begin
				rot_q <= io_wdata & VGC_WM_ROT;
			end else if (gc_idx_q == VGC_GI_RMAP) begin
				rmap_q <= io_wdata & VGC_WM_RMAP;
			end else if (gc_idx_q == VGC_GI_MODE) begin
				mode_q <= io_wdata & VGC_WM_MODE;
			end else if (gc_idx_q == VGC_GI_MISC) begin
				gmisc_q <= io_wdata & VGC_WM_MISC;
			end else if (gc_idx_q == VGC_GI_CARE) begin
				care_q <= io_wdata & VGC_WM_NIB;
			end else if (gc_idx_q == VGC_GI_MASK) begin
				mask_q <= io_wdata;
			end
		end
	end
	// Sequencer data registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			srst_q  <= VGC_RST_ZERO;
			sclk_q  <= VGC_RST_ZERO;
			mmask_q <= VGC_RST_ZERO;
			cmap_q  <= VGC_RST_ZERO;
			smem_q  <= VGC_RST_ZERO;
		end else if (io_wr && io_addr == VGC_ADR_SEQ_D) begin
			if (seq_idx_q == VGC_SI_RST) begin
				srst_q <= io_wdata & VGC_WM_SRST;
			end else if (seq_idx_q == VGC_SI_CLK) begin
				sclk_q <= io_wdata & VGC_WM_SCLK;
			end else if (seq_idx_q == VGC_SI_MMASK) begin
				mmask_q <= io_wdata & VGC_WM_NIB;
			end else if (seq_idx_q == VGC_SI_CMAP) begin
				cmap_q <= io_wdata & VGC_WM_SCMAP;
			end else if (seq_idx_q == VGC_SI_MEM) begin
				smem_q <= io_wdata & VGC_WM_SMEM;
			end
		end
	end
	// Indexed read muxes; reserved indices read zero
	always_comb begin
		case (gc_idx_q)
			VGC_GI_SETRST: gc_rd = setrst_q;
			VGC_GI_SRENA:  gc_rd = srena_q;
			VGC_GI_CCMP:   gc_rd = ccmp_q;
			VGC_GI_ROT:    gc_rd = rot_q;
			VGC_GI_RMAP:   gc_rd = rmap_q;
			VGC_GI_MODE:   gc_rd = mode_q;
			VGC_GI_MISC:   gc_rd = gmisc_q;
			VGC_GI_CARE:   gc_rd = care_q;
			VGC_GI_MASK:   gc_rd = mask_q;
			default:       gc_rd = VGC_RST_ZERO;
		endcase
		case (seq_idx_q)
			VGC_SI_RST:   seq_rd = srst_q;
			VGC_SI_CLK:   seq_rd = sclk_q;
			VGC_SI_MMASK: seq_rd = mmask_q;
			VGC_SI_CMAP:  seq_rd = cmap_q;
			VGC_SI_MEM:   seq_rd = smem_q;
			default:      seq_rd = VGC_RST_ZERO;
		endcase
	end
	// Diagnostic pair from attribute colour outputs
	always_comb begin
		case (colour_mux_sel)
			2'h0:    diag = {attr_colour[2], attr_colour[0]};
			2'h1:    diag = {attr_colour[5], attr_colour[4]};
			2'h2:    diag = {attr_colour[3], attr_colour[1]};
			default: diag = {attr_colour[7], attr_colour[6]};
		endcase
	end
	// Input status registers
	always_comb begin
		stat0 = VGC_INPUT_STATUS_ZERO_FIX;
		stat0[VGC_F_VINT] = vint_pending;
		stat1 = VGC_RST_ZERO;
		stat1[VGC_F_DISP] = disp_inactive;
		stat1[VGC_F_VRET] = vretrace_act;
		stat1[VGC_F_DIAG_LO +: 2] = diag;
	end
	// Registered I/O read data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= VGC_RST_ZERO;
		end else if (io_rd) begin
			if (io_addr == VGC_ADR_INPUT_STATUS_ZERO) begin
				io_rdata <= stat0;
			end else if (io_addr == VGC_ADR_MISC_R) begin
				io_rdata <= misc_q;
			end else if (stat_addr) begin
				io_rdata <= stat1;
			end else if (io_addr == VGC_ADR_GC_X) begin
				io_rdata <= {4'h0, gc_idx_q};
			end else if (io_addr == VGC_ADR_GC_D) begin
				io_rdata <= gc_rd;
			end else if (io_addr == VGC_ADR_SEQ_X) begin
				io_rdata <= {5'h00, seq_idx_q};
			end else if (io_addr == VGC_ADR_SEQ_D) begin
				io_rdata <= seq_rd;
			end else begin
				io_rdata <= VGC_RST_ZERO;
			end
		end
	end
	// Decoded port hit
	assign io_hit = io_addr == VGC_ADR_INPUT_STATUS_ZERO || io_addr == VGC_ADR_MISC_R
		|| stat_addr || io_addr == VGC_ADR_GC_X || io_addr == VGC_ADR_GC_D
		|| io_addr == VGC_ADR_SEQ_X || io_addr == VGC_ADR_SEQ_D;
	// Host window decode
	assign pg = mem_addr[19:12];
	always_comb begin
		case (gmisc_q[VGC_F_MAP_LO +: 2])
			VGC_MAP_128K: in_win = pg >= VGC_WIN_A0 && pg < VGC_WIN_END;
			VGC_MAP_A64K: in_win = pg >= VGC_WIN_A0 && pg < VGC_WIN_B0;
			VGC_MAP_B32K: in_win = pg >= VGC_WIN_B0 && pg < VGC_WIN_B8;
			default:      in_win = pg >= VGC_WIN_B8 && pg < VGC_WIN_END;
		endcase
	end
	assign mem_hit = in_win && misc_q[VGC_F_RAMEN];
	// Memory address with chain odd/even substitution
	always_comb begin
		vram_addr = mem_addr[15:0];
		if (gmisc_q[VGC_F_CHODD]) begin
			if (gmisc_q[VGC_F_MAP_LO +: 2] == VGC_MAP_128K) begin
				vram_addr[0] = mem_addr[VGC_HOST_A16];
			end else begin
				vram_addr[0] = misc_q[VGC_F_PAGE];
			end
		end
	end
	// Read plane: chain four, odd/even, or map field
	assign chain_four_bit = smem_q[VGC_F_CHAIN_FOUR_BIT];
	always_comb begin
		rd_plane = rmap_q[1:0];
		if (chain_four_bit) begin
			rd_plane = mem_addr[1:0];
		end else if (mode_q[VGC_F_RODDEV]) begin
			rd_plane[0] = mem_addr[0];
		end
	end
	// Plane write enables from map mask, or one-hot from address bits 1:0 in chain four
	assign we_planes = chain_four_bit ? 4'(4'h1 << mem_addr[1:0]) : mmask_q[3:0];
	assign vram_plane_we = (mem_wr && mem_hit) ? we_planes : 4'h0;
	// Processor latches load on every frame buffer read that hits the window with RAM enabled
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= 32'h0000_0000;
		end else if (mem_rd && mem_hit) begin
			latch_q <= vram_rdata;
		end
	end
	// Registered host read data
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rdata <= VGC_RST_ZERO;
		end else if (mem_rd && mem_hit) begin
			mem_rdata <= rd_byte;
		end
	end
	// Read datapath
	vgc_read_path u_rd (
		.rd_mode    (mode_q[VGC_F_RDMODE]),
		.plane_sel  (rd_plane),
		.ref_colour (ccmp_q[3:0]),
		.care_en    (care_q[3:0]),
		.latch_data (vram_rdata),
		.read_byte  (rd_byte)
	);
	// Write datapath
	vgc_write_path u_wr (
		.wr_mode      (mode_q[VGC_F_WRM_LO +: 2]),
		.rot_cnt      (rot_q[VGC_F_ROT_LO +: 3]),
		.func_sel     (rot_q[VGC_F_FUN_LO +: 2]),
		.set_reset    (setrst_q[3:0]),
		.set_reset_en (srena_q[3:0]),
		.bit_mask     (mask_q),
		.host_byte    (mem_wdata),
		.latch_data   (latch_q),
		.plane_out    (wr_planes)
	);
	assign vram_wdata = wr_planes;
	// Display side controls
	assign crtc_cga_map         = misc_q[VGC_F_IOSEL];
	assign clock_source         = misc_q[VGC_F_CLK_LO +: 2];
	assign ext_pixel_clk        = misc_q[VGC_F_CLK_LO + 1];
	assign graphics_mode        = gmisc_q[VGC_F_GRSEL];
	assign interleave_en        = mode_q[VGC_F_INTLV];
	assign wide_colour_load_bit = mode_q[VGC_F_WIDE];
	assign seq_clock_mode       = sclk_q;
	// Sync polarity inversion
	assign hsync_out = hsync_raw ^ misc_q[VGC_F_HPOL];
	assign vsync_out = vsync_raw ^ misc_q[VGC_F_VPOL];
	// Checks
	a_sync_polar: assert property (@(posedge sys_clk) disable iff (!rst_n)
		hsync_out == (hsync_raw ^ misc_q[VGC_F_HPOL]))
		else $error("hsync polarity wrong");
	a_status_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(io_rd && io_addr == VGC_ADR_INPUT_STATUS_ZERO) |=> io_rdata[6:4] == 3'h7)
		else $error("status 0 fixed bits wrong");
	a_vint_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(io_rd && io_addr == VGC_ADR_INPUT_STATUS_ZERO)
		|=> io_rdata[VGC_F_VINT] == $past(vint_pending))
		else $error("retrace interrupt bit wrong");
	a_stat1_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(io_rd && stat_addr && io_addr != VGC_ADR_INPUT_STATUS_ZERO)
		|=> io_rdata[VGC_F_VRET] == $past(vretrace_act)
		&& io_rdata[VGC_F_DISP] == $past(disp_inactive))
		else $error("status 1 bits wrong");
	a_mode1_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_q[1:0] == VGC_WM1 |-> vram_wdata == latch_q)
		else $error("mode 1 not latch copy");
	a_mask_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_q[1:0] != VGC_WM3 |-> ((vram_wdata ^ latch_q)
		& ~{4{mask_q}}) == 32'h0)
		else $error("masked bit changed");
	a_chain_a0: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(gmisc_q[VGC_F_CHODD] && gmisc_q[3:2] == VGC_MAP_128K)
		|-> vram_addr[0] == mem_addr[VGC_HOST_A16])
		else $error("chain odd/even address wrong");
	a_win_a64: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(gmisc_q[3:2] == VGC_MAP_A64K && pg >= VGC_WIN_B0) |-> !in_win)
		else $error("window decode wrong");
	a_plane_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(mem_rd && mem_hit && !mode_q[VGC_F_RDMODE] && !chain_four_bit
		&& !mode_q[VGC_F_RODDEV])
		|=> mem_rdata == $past(vram_rdata[rmap_q[1:0]*8 +: 8]))
		else $error("plane read wrong");
endmodule

/* test/vgc_vram_model.sv */
// Video memory stand-in: four byte planes with per-plane writes
`timescale 1ns/1ps
module vgc_vram_model (
	// Clock
	input  wire logic        clk,
	// Memory port
	input  wire logic [15:0] addr,
	input  wire logic [3:0]  we,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);
	logic [31:0] mem [0:255];
	// Same-cycle read, upper address bits alias
	assign rdata = mem[addr[7:0]];
	// Plane writes on the clock edge
	always @(posedge clk) begin
		for (int p = 0; p < 4; p++) begin
			if (we[p]) begin
				mem[addr[7:0]][8*p +: 8] <= wdata[8*p +: 8];
			end
		end
	end
endmodule

/* test/vgc_regs_bench.sv */
// Self-checking bench for the graphics controller register bank
`timescale 1ns/1ps
module vgc_regs_bench;
	import vgc_pkg::*;
	localparam logic [31:0] W = 32'h44332211;
	localparam logic [19:0] WLO [4] = '{20'hA0000, 20'hA0000, 20'hB0000,
		20'hB8000};
	localparam logic [19:0] WHI [4] = '{20'hBFFFF, 20'hAFFFF, 20'hB7FFF,
		20'hBFFFF};
	localparam logic [19:0] PRB [8] = '{20'h9FFFF, 20'hA0000, 20'hAFFFF,
		20'hB0000, 20'hB7FFF, 20'hB8000, 20'hBFFFF, 20'hC0000};
	localparam int          DHI [4] = '{2, 5, 3, 7};
	localparam int          DLO [4] = '{0, 4, 1, 6};
	localparam logic [15:0] CMP [4] = '{16'h1111, 16'h00FF, 16'h08BB,
		16'h5F11};
	logic        sys_clk, arst_n, io_wr, io_rd, mem_wr, mem_rd, io_hit;
	logic        mem_hit, vint_pending, disp_inactive, vretrace_act;
	logic        hsync_raw, vsync_raw, crtc_cga_map, ext_pixel_clk;
	logic        hsync_out, vsync_out, graphics_mode, interleave_en;
	logic        wide_colour_load_bit;
	logic [1:0]  colour_mux_sel, clock_source;
	logic [3:0]  vram_plane_we;
	logic [7:0]  io_wdata, io_rdata, mem_wdata, mem_rdata, attr_colour;
	logic [7:0]  seq_clock_mode, rd;
	logic [15:0] io_addr, vram_addr;
	logic [19:0] mem_addr;
	logic [31:0] vram_rdata, vram_wdata, e;
	int          n_mismatch, num_checks;

	vgc_regs i_dut (.sys_clk, .arst_n, .io_addr, .io_wr, .io_rd, .io_wdata,
		.io_rdata, .io_hit, .mem_addr, .mem_wr, .mem_rd, .mem_wdata,
		.mem_rdata, .mem_hit, .vram_rdata, .vram_wdata, .vram_addr,
		.vram_plane_we, .vint_pending, .disp_inactive, .vretrace_act,
		.colour_mux_sel, .attr_colour, .hsync_raw, .vsync_raw,
		.crtc_cga_map, .clock_source, .ext_pixel_clk, .hsync_out,
		.vsync_out, .graphics_mode, .interleave_en, .wide_colour_load_bit,
		.seq_clock_mode);
	vgc_vram_model i_mem (.clk(sys_clk), .addr(vram_addr),
		.we(vram_plane_we), .wdata(vram_wdata), .rdata(vram_rdata));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// Port accesses
	task automatic iow(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge sys_clk);
		io_wr <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic ior(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge sys_clk);
		io_rd <= 1'b0;
		@(negedge sys_clk);
		d = io_rdata;
	endtask
	task automatic gw(input logic [7:0] i, input logic [7:0] d);
		iow(VGC_ADR_GC_X, i);
		iow(VGC_ADR_GC_D, d);
	endtask
	task automatic gr(input logic [7:0] i, output logic [7:0] d);
		iow(VGC_ADR_GC_X, i);
		ior(VGC_ADR_GC_D, d);
	endtask
	// Frame buffer accesses
	task automatic mw(input logic [19:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		mem_addr <= a;
		mem_wdata <= d;
		mem_wr <= 1'b1;
		@(posedge sys_clk);
		mem_wr <= 1'b0;
	endtask
	task automatic mr(input logic [19:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		mem_addr <= a;
		mem_rd <= 1'b1;
		@(posedge sys_clk);
		mem_rd <= 1'b0;
		@(negedge sys_clk);
		d = mem_rdata;
	endtask
	// Address probe, then peek at a plane word
	task automatic at(input logic [19:0] a);
		@(posedge sys_clk);
		mem_addr <= a;
		@(negedge sys_clk);
	endtask
	task automatic pk(input int i, input logic [31:0] x);
		#1;
		chk(i_mem.mem[i], x);
	endtask
	// Verdict
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{arst_n, io_wr, io_rd, mem_wr, mem_rd, vint_pending} = '0;
		{disp_inactive, vretrace_act, colour_mux_sel} = '0;
		{hsync_raw, vsync_raw} = 2'b11;
		{io_addr, io_wdata, mem_addr, mem_wdata} = '0;
		attr_colour = 8'hA5;
		n_mismatch = 0;
		num_checks = 0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		gr(8'h08, rd);
		chk(rd, 8'hFF);
		ior(VGC_ADR_MISC_R, rd);
		chk(rd, 8'h00);
		ior(VGC_ADR_INPUT_STATUS_ZERO, rd);
		chk(rd, 8'h70);
		@(posedge sys_clk);
		vint_pending <= 1'b1;
		ior(VGC_ADR_INPUT_STATUS_ZERO, rd);
		chk(rd, 8'hF0);
		$display("test reset and status0 done");
		iow(VGC_ADR_MISC_W, 8'hDE);
		ior(VGC_ADR_MISC_R, rd);
		chk(rd, 8'hCE);
		chk({clock_source, ext_pixel_clk, hsync_out, vsync_out}, 5'h1C);
		ior(VGC_ADR_INPUT_STATUS_ZERO, rd);
		chk(rd, 8'hF0);
		iow(VGC_ADR_MISC_W, 8'h07);
		chk({clock_source, ext_pixel_clk, hsync_out, vsync_out}, 5'h0B);
		chk(crtc_cga_map, 1'b1);
		for (int m = 0; m < 4; m++) begin
			@(posedge sys_clk);
			colour_mux_sel <= 2'(m);
			vretrace_act <= 1'(m);
			disp_inactive <= 1'(m >> 1);
			ior(VGC_ADR_STAT_C, rd);
			chk(rd, {2'b00, attr_colour[DHI[m]], attr_colour[DLO[m]],
				1'(m), 2'b00, 1'(m >> 1)});
		end
		chk(io_hit, 1'b1);
		$display("test misc and status1 done");
		iow(VGC_ADR_MISC_W, 8'h06);
		ior(VGC_ADR_STAT_C, rd);
		chk(io_hit, 1'b0);
		chk(rd, 8'h00);
		sw_block: begin
			iow(VGC_ADR_SEQ_X, 8'h02);
			iow(VGC_ADR_SEQ_D, 8'h0F);
		end
		for (int c = 0; c < 4; c++) begin
			gw(8'h06, 8'(c << 2));
			for (int k = 0; k < 8; k++) begin
				at(PRB[k]);
				chk(mem_hit, PRB[k] >= WLO[c] && PRB[k] <= WHI[c]);
			end
		end
		gw(8'h06, 8'h02);
		at(20'hB0002);
		chk(vram_addr[0], 1'b1);
		at(20'hA0003);
		chk(vram_addr[0], 1'b0);
		gw(8'h06, 8'h06);
		iow(VGC_ADR_MISC_W, 8'h26);
		at(20'hA0002);
		chk(vram_addr[0], 1'b1);
		iow(VGC_ADR_MISC_W, 8'h06);
		gw(8'h06, 8'h00);
		$display("test windows done");
		for (int k = 0; k < 64; k++) begin
			i_mem.mem[k] = W;
		end
		gw(8'h03, 8'h01);
		mw(20'hA0010, 8'h81);
		pk(16, 32'hC0C0C0C0);
		for (int p = 0; p < 4; p++) begin
			gw(8'h04, 8'(p));
			mr(20'hA0020, rd);
			chk(rd, W[8*p +: 8]);
		end
		gw(8'h04, 8'h00);
		gw(8'h05, 8'h10);
		mr(20'hA0021, rd);
		chk(rd, 8'h22);
		gw(8'h05, 8'h08);
		for (int k = 0; k < 4; k++) begin
			gw(8'h02, {4'h0, CMP[k][15:12]});
			gw(8'h07, {4'h0, CMP[k][11:8]});
			mr(20'hA0020, rd);
			chk(rd, CMP[k][7:0]);
		end
		gw(8'h05, 8'h00);
		iow(VGC_ADR_SEQ_X, 8'h04);
		iow(VGC_ADR_SEQ_D, 8'h08);
		mr(20'hA0022, rd);
		chk(rd, 8'h33);
		iow(VGC_ADR_SEQ_D, 8'h00);
		$display("test reads done");
		for (int f = 0; f < 4; f++) begin
			mr(20'hA0020, rd);
			gw(8'h03, 8'(f << 3));
			mw(20'hA0030, 8'hF0);
			case (f)
				0: e = {4{8'hF0}};
				1: e = {4{8'hF0}} & W;
				2: e = {4{8'hF0}} | W;
				default: e = {4{8'hF0}} ^ W;
			endcase
			pk(48, e);
		end
		gw(8'h03, 8'h00);
		gw(8'h08, 8'h0F);
		mr(20'hA0020, rd);
		mw(20'hA0031, 8'hFF);
		pk(49, 32'h4F3F2F1F);
		gw(8'h08, 8'hFF);
		gw(8'h00, 8'h0A);
		gw(8'h01, 8'h03);
		mw(20'hA0032, 8'h5A);
		pk(50, 32'h5A5AFF00);
		gw(8'h01, 8'h00);
		mr(20'hA0020, rd);
		gw(8'h05, 8'h01);
		mw(20'hA0040, 8'h00);
		pk(64, W);
		gw(8'h05, 8'h02);
		mw(20'hA0041, 8'h05);
		pk(65, 32'h00FF00FF);
		gw(8'h03, 8'h01);
		gw(8'h08, 8'hF0);
		mr(20'hA0020, rd);
		gw(8'h05, 8'h03);
		mw(20'hA0042, 8'h0F);
		pk(66, 32'hC433A211);
		$display("test write modes done");
		gw(8'h05, 8'hFF);
		gr(8'h05, rd);
		chk(rd, 8'h7B);
		gw(8'h06, 8'h01);
		chk({graphics_mode, interleave_en, wide_colour_load_bit}, 3'h7);
		gw(8'h05, 8'h00);
		gw(8'h06, 8'h00);
		chk({graphics_mode, interleave_en, wide_colour_load_bit}, 3'h0);
		$display("test mode controls done");
		wrap_up();
	end
endmodule
